// ===== hw/irq_ctl.sv
/*
 * Input interrupt control: four inputs, command decoder, APB registers.
 * Assumes irq_in and svc_done synchronous to mclk; APB master obeys protocol.
 */
`timescale 1ns/1ps
module irq_ctl (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [3:0]  irq_in,
    input  wire logic        svc_done,
    output logic [3:0]       svc_req,
    output logic             svc_active,
    output logic             error_flag,
    output logic             irq,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);
    setval_if cs();

    logic [11:0]  code_reg;
    logic [15:0]  word_reg;
    logic [15:0]  result_reg;
    logic [2:0]   status_reg;
    logic [2:0]   imask_reg;
    logic [3:0]   mask_reg;
    logic         gmask_reg;
    logic [3:0]   pend_reg;
    logic [3:0]   irq_prev_reg;
    logic [3:0]   svc_reg;
    logic         svc_act_reg;
    logic [31:0]  prdata_reg;
    irq_ctl_pkg::cmd_state_e state_reg;

    logic         wr_en;
    logic         rd_en;
    logic         go;
    logic         exec;
    logic         err_ev;
    logic         done_ev;
    logic         svc_ev;
    logic         bad_code;
    logic         bad_word;
    logic [3:0]   rise;
    logic [3:0]   eligible;
    logic [3:0]   grant;
    logic [3:0]   clr_sel;
    logic [31:0]  rd_mux;
    logic         addr_ok;

    // -------------------------------------------------------------
    // APB slave
    // -------------------------------------------------------------
    // Zero wait state: access phase always completes
    assign pready  = 1'b1;
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;
    assign go      = wr_en && (paddr == irq_ctl_pkg::OFS_CMD) && pwdata[irq_ctl_pkg::CMD_GO];

    // Address check for slave error on unmapped words
    always_comb begin
        addr_ok = 1'b1;
        if (paddr == irq_ctl_pkg::OFS_CMD || paddr == irq_ctl_pkg::OFS_WORD) begin
            addr_ok = 1'b1;
        end else if (paddr == irq_ctl_pkg::OFS_RESULT || paddr == irq_ctl_pkg::OFS_STATUS) begin
            addr_ok = 1'b1;
        end else if (paddr == irq_ctl_pkg::OFS_INT_MASK || paddr == irq_ctl_pkg::OFS_PENDING) begin
            addr_ok = 1'b1;
        end else if (paddr == irq_ctl_pkg::OFS_SERVICE) begin
            addr_ok = 1'b1;
        end else if (paddr >= irq_ctl_pkg::OFS_SET_BASE && paddr < irq_ctl_pkg::OFS_SET_LIMIT
                     && paddr[1:0] == 2'b00) begin
            addr_ok = 1'b1;
        end else begin
            addr_ok = 1'b0;
        end
    end
    assign pslverr = psel && penable && !addr_ok;

    // Read mux
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (paddr == irq_ctl_pkg::OFS_CMD) begin
            rd_mux = {20'h00000, code_reg};
        end else if (paddr == irq_ctl_pkg::OFS_WORD) begin
            rd_mux = {16'h0000, word_reg};
        end else if (paddr == irq_ctl_pkg::OFS_RESULT) begin
            rd_mux = {16'h0000, result_reg};
        end else if (paddr == irq_ctl_pkg::OFS_STATUS) begin
            rd_mux = {29'h0000_0000, status_reg};
        end else if (paddr == irq_ctl_pkg::OFS_INT_MASK) begin
            rd_mux = {29'h0000_0000, imask_reg};
        end else if (paddr == irq_ctl_pkg::OFS_PENDING) begin
            rd_mux = {23'h000000, gmask_reg, mask_reg, pend_reg};
        end else if (paddr == irq_ctl_pkg::OFS_SERVICE) begin
            rd_mux = {27'h0000000, svc_act_reg, svc_reg};
        end else if (paddr >= irq_ctl_pkg::OFS_SET_BASE && paddr < irq_ctl_pkg::OFS_SET_LIMIT) begin
            rd_mux = {cs.cnt_out[paddr[3:2]], cs.set_out[paddr[3:2]]};
        end
    end

    // Read data registered on the access edge
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prdata_reg <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata_reg <= rd_mux;
        end
    end
    // Read data comes straight from mux so it is valid in the access cycle
    assign prdata = rd_en ? rd_mux : prdata_reg;

    // Command code and word registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            code_reg <= 12'h000;
            word_reg <= 16'h0000;
        end else if (wr_en && paddr == irq_ctl_pkg::OFS_CMD) begin
            code_reg <= pwdata[11:0];
        end else if (wr_en && paddr == irq_ctl_pkg::OFS_WORD) begin
            word_reg <= pwdata[15:0];
        end
    end

    // Interrupt mask register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            imask_reg <= 3'h0;
        end else if (wr_en && paddr == irq_ctl_pkg::OFS_INT_MASK) begin
            imask_reg <= pwdata[2:0];
        end
    end

    // -------------------------------------------------------------
    // Command sequencer
    // -------------------------------------------------------------
    // act only on a go strobe
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= irq_ctl_pkg::ST_IDLE;
        end else begin
            case (state_reg)
                irq_ctl_pkg::ST_IDLE: begin
                    if (go) begin
                        state_reg <= irq_ctl_pkg::ST_EXEC;
                    end
                end
                irq_ctl_pkg::ST_EXEC: begin
                    state_reg <= irq_ctl_pkg::ST_FIN;
                end
                default: begin
                    state_reg <= irq_ctl_pkg::ST_IDLE;
                end
            endcase
        end
    end
    assign exec = (state_reg == irq_ctl_pkg::ST_EXEC);

    always_comb begin
        case (code_reg)
            irq_ctl_pkg::CODE_MASK, irq_ctl_pkg::CODE_CLEAR,
            irq_ctl_pkg::CODE_READ, irq_ctl_pkg::CODE_RELOAD,
            irq_ctl_pkg::CODE_MASK_ALL, irq_ctl_pkg::CODE_UNM_ALL: bad_code = 1'b0;
            default: bad_code = 1'b1;
        endcase
    end
    // upper word bits must be zero except for read, global ops need whole word zero
    assign bad_word = (code_reg == irq_ctl_pkg::CODE_MASK_ALL
                       || code_reg == irq_ctl_pkg::CODE_UNM_ALL) ? (word_reg != 16'h0000)
                    : (code_reg == irq_ctl_pkg::CODE_READ) ? 1'b0
                    : ((word_reg & ~irq_ctl_pkg::WORD_USED) != 16'h0000);

    always_comb begin
        err_ev = 1'b0;
        if (exec) begin
            if (bad_code || bad_word) begin
                err_ev = 1'b1;
            end else if (code_reg == irq_ctl_pkg::CODE_RELOAD) begin
                err_ev = cs.reload_bad;
            end else if (code_reg == irq_ctl_pkg::CODE_MASK_ALL) begin
                err_ev = svc_act_reg || gmask_reg;
            end else if (code_reg == irq_ctl_pkg::CODE_UNM_ALL) begin
                err_ev = svc_act_reg || !gmask_reg;
            end
        end
    end
    assign done_ev = exec;

    // operations decoded in the execute cycle
    wire op_ok = exec && !bad_code && !bad_word;

    // reload strobe to set value store
    assign cs.reload_sel = (op_ok && code_reg == irq_ctl_pkg::CODE_RELOAD) ? word_reg[3:0] : 4'h0;
    assign cs.load_val   = pwdata[15:0];

    // Set value write strobes, one per word
    genvar gi;
    generate
        for (gi = 0; gi < irq_ctl_pkg::NUM_IN; gi++) begin : g_ld
            assign cs.load_sel[gi] = wr_en && paddr[11:4] == irq_ctl_pkg::OFS_SET_BASE[11:4]
                                     && paddr[3:2] == 2'(gi) && paddr[1:0] == 2'b00;
        end
    endgenerate

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mask_reg <= 4'h0;
        end else if (op_ok && code_reg == irq_ctl_pkg::CODE_MASK) begin
            mask_reg <= word_reg[3:0];
        end
    end

    // global mask, held only when the error checks pass
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            gmask_reg <= 1'b0;
        end else if (op_ok && !err_ev && code_reg == irq_ctl_pkg::CODE_MASK_ALL) begin
            gmask_reg <= 1'b1;
        end else if (op_ok && !err_ev && code_reg == irq_ctl_pkg::CODE_UNM_ALL) begin
            gmask_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            result_reg <= 16'h0000;
        end else if (op_ok && code_reg == irq_ctl_pkg::CODE_READ) begin
            result_reg <= {12'h000, mask_reg};
        end
    end

    // -------------------------------------------------------------
    // Pending latches and service
    // -------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_prev_reg <= 4'h0;
        end else begin
            irq_prev_reg <= irq_in;
        end
    end
    assign rise     = irq_in & ~irq_prev_reg;
    // only unmasked pending inputs may start a routine
    assign eligible = pend_reg & ~mask_reg & {4{!gmask_reg}};
    // Lowest input wins when several become eligible together
    assign grant    = svc_act_reg ? 4'h0 : (eligible & (~eligible + 4'h1));
    assign clr_sel  = (op_ok && code_reg == irq_ctl_pkg::CODE_CLEAR) ? word_reg[3:0] : 4'h0;

    // set wins over service and clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pend_reg <= 4'h0;
        end else begin
            pend_reg <= (pend_reg & ~grant & ~clr_sel) | rise;
        end
    end

    // Service in progress tracking
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            svc_reg     <= 4'h0;
            svc_act_reg <= 1'b0;
        end else if (grant != 4'h0) begin
            svc_reg     <= grant;
            svc_act_reg <= 1'b1;
        end else if (svc_done) begin
            svc_reg     <= 4'h0;
            svc_act_reg <= 1'b0;
        end
    end
    assign svc_ev     = grant != 4'h0;
    assign svc_req    = svc_reg;
    assign svc_active = svc_act_reg;

    // -------------------------------------------------------------
    // Sticky status and interrupt
    // -------------------------------------------------------------
    // Set wins over write-one-to-clear so no event is lost
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            status_reg <= 3'h0;
        end else begin
            status_reg <= (status_reg & ~((wr_en && paddr == irq_ctl_pkg::OFS_STATUS)
                           ? pwdata[2:0] : 3'h0)) | {svc_ev, done_ev, err_ev};
        end
    end
    assign error_flag = status_reg[irq_ctl_pkg::ST_ERR];
    assign irq        = |(status_reg & imask_reg);

    setval_store u_setval (
        .mclk (mclk),
        .rst  (rst),
        .cs   (cs.store)
    );

    // -------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------
    property p_no_exec_idle;
        @(posedge mclk) disable iff (rst)
        (state_reg == irq_ctl_pkg::ST_IDLE && !go) |=> !exec;
    endproperty
    a_no_exec_idle: assert property (p_no_exec_idle) else $error("exec without go");

    property p_go_exec;
        @(posedge mclk) disable iff (rst)
        (state_reg == irq_ctl_pkg::ST_IDLE && go) |=> exec ##1 !exec;
    endproperty
    a_go_exec: assert property (p_go_exec) else $error("go not executed once");

    property p_mask_set;
        @(posedge mclk) disable iff (rst)
        (op_ok && code_reg == irq_ctl_pkg::CODE_MASK) |=> mask_reg == $past(word_reg[3:0]);
    endproperty
    a_mask_set: assert property (p_mask_set) else $error("mask not loaded");

    property p_masked_no_grant;
        @(posedge mclk) disable iff (rst)
        (mask_reg != 4'h0 || gmask_reg) |-> (grant & (mask_reg | {4{gmask_reg}})) == 4'h0;
    endproperty
    a_masked_no_grant: assert property (p_masked_no_grant) else $error("masked served");

    property p_clear;
        @(posedge mclk) disable iff (rst)
        (clr_sel != 4'h0) |=> ((pend_reg & $past(clr_sel) & ~$past(rise)) == 4'h0);
    endproperty
    a_clear: assert property (p_clear) else $error("clear failed");

    property p_read;
        @(posedge mclk) disable iff (rst)
        (op_ok && code_reg == irq_ctl_pkg::CODE_READ) |=> result_reg == {12'h000, mask_reg};
    endproperty
    a_read: assert property (p_read) else $error("read wrong");

    property p_gmask_busy;
        @(posedge mclk) disable iff (rst)
        (exec && svc_act_reg && (code_reg == irq_ctl_pkg::CODE_MASK_ALL
         || code_reg == irq_ctl_pkg::CODE_UNM_ALL)) |=> error_flag && $stable(gmask_reg);
    endproperty
    a_gmask_busy: assert property (p_gmask_busy) else $error("busy global op");

    property p_gmask_twice;
        @(posedge mclk) disable iff (rst)
        (exec && gmask_reg && code_reg == irq_ctl_pkg::CODE_MASK_ALL) |=> error_flag;
    endproperty
    a_gmask_twice: assert property (p_gmask_twice) else $error("double mask");

    property p_bad_code;
        @(posedge mclk) disable iff (rst)
        (exec && bad_code) |=> error_flag && $stable(mask_reg) && $stable(gmask_reg);
    endproperty
    a_bad_code: assert property (p_bad_code) else $error("bad code acted");

    property p_pend_set;
        @(posedge mclk) disable iff (rst)
        (rise != 4'h0) |=> ((pend_reg & $past(rise)) == $past(rise));
    endproperty
    a_pend_set: assert property (p_pend_set) else $error("event lost");

    c_grant: cover property (@(posedge mclk) disable iff (rst) svc_ev);
    c_err: cover property (@(posedge mclk) disable iff (rst) err_ev);
    c_gmask: cover property (@(posedge mclk) disable iff (rst) $rose(gmask_reg));
    c_reload: cover property (@(posedge mclk) disable iff (rst) cs.reload_sel != 4'h0);
endmodule : irq_ctl

// ===== hw/irq_ctl_pkg.sv
/*
 * Constants and types for the input interrupt control block.
 * Assumes one system clock; used by irq_ctl and setval_store, not by the interface.
 */
package irq_ctl_pkg;
    // -------------------------------------------------------------
    // Register map (byte addresses)
    // -------------------------------------------------------------
    localparam logic [11:0] OFS_CMD       = 12'h000;
    localparam logic [11:0] OFS_WORD      = 12'h004;
    localparam logic [11:0] OFS_RESULT    = 12'h008;
    localparam logic [11:0] OFS_STATUS    = 12'h00c;
    localparam logic [11:0] OFS_INT_MASK  = 12'h010;
    localparam logic [11:0] OFS_PENDING   = 12'h014;
    localparam logic [11:0] OFS_SET_BASE  = 12'h020;
    localparam logic [11:0] OFS_SET_LIMIT = 12'h030;
    localparam logic [11:0] OFS_SERVICE   = 12'h040;

    // -------------------------------------------------------------
    // Command codes
    // -------------------------------------------------------------
    localparam logic [11:0] CODE_MASK     = 12'h000;
    localparam logic [11:0] CODE_CLEAR    = 12'h001;
    localparam logic [11:0] CODE_READ     = 12'h002;
    localparam logic [11:0] CODE_RELOAD   = 12'h003;
    localparam logic [11:0] CODE_MASK_ALL = 12'h100;
    localparam logic [11:0] CODE_UNM_ALL  = 12'h200;

    // Number of inputs and word layout
    localparam int          NUM_IN        = 4;
    localparam logic [15:0] WORD_USED     = 16'h000f;
    localparam logic [15:0] SET_MIN       = 16'h0001;

    // Status bits and command go bit
    localparam int          ST_ERR        = 0;
    localparam int          ST_DONE       = 1;
    localparam int          ST_SVC        = 2;
    localparam int          CMD_GO        = 31;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_FIN  = 2'b11
    } cmd_state_e;
endpackage : irq_ctl_pkg

// ===== hw/sv_if.sv
/*
 * Interface between command decoder and counter set value store.
 * Assumes both ends share mclk.
 */
`timescale 1ns/1ps
interface setval_if;
    logic [3:0]  load_sel;
    logic [15:0] load_val;
    logic [3:0]  reload_sel;
    logic        reload_bad;
    logic [15:0] set_out [4];
    logic [15:0] cnt_out [4];
    modport ctl (output load_sel, load_val, reload_sel, input reload_bad, set_out, cnt_out);
    modport store (input load_sel, load_val, reload_sel, output reload_bad, set_out, cnt_out);
endinterface : setval_if

// ===== hw/sv_store.sv
/*
 * Counter set value store: four programmed set values and working counters.
 * Assumes load and reload selects are one-cycle pulses from the decoder.
 */
`timescale 1ns/1ps
module setval_store (
    input  wire logic mclk,
    input  wire logic rst,
    setval_if.store   cs
);
    logic [15:0] set_reg [4];
    logic [15:0] cnt_reg [4];
    logic [3:0]  bad;

    // -------------------------------------------------------------
    // Per input storage
    // -------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < irq_ctl_pkg::NUM_IN; g++) begin : g_in
            // Set value written by software
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    set_reg[g] <= 16'h0000;
                end else if (cs.load_sel[g]) begin
                    set_reg[g] <= cs.load_val;
                end
            end
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    cnt_reg[g] <= 16'h0000;
                end else if (cs.reload_sel[g] && !bad[g]) begin
                    cnt_reg[g] <= set_reg[g];
                end
            end
            assign bad[g]         = cs.reload_sel[g] && (set_reg[g] < irq_ctl_pkg::SET_MIN);
            assign cs.set_out[g]  = set_reg[g];
            assign cs.cnt_out[g]  = cnt_reg[g];
        end
    endgenerate

    assign cs.reload_bad = |bad;
endmodule : setval_store

// ===== tb/input_interrupt_control_tb.sv
/*
 * Self-checking bench for irq_ctl: APB register tasks, command runs, input pulses.
 * Assumes zero-wait APB answers and a command that settles within three edges after go.
 */
`timescale 1ns/1ps
module input_interrupt_control_tb;
    typedef struct {logic [31:0] d; logic [31:0] m; logic e;} note_s;
    logic        mclk;
    logic        rst;
    logic        svc_done;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic        pready;
    logic        pslverr;
    logic        svc_active;
    logic        error_flag;
    logic        irq;
    logic        imask;
    logic [3:0]  irq_in;
    logic [3:0]  svc_req;
    logic [3:0]  msk;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    note_s       q[$];
    note_s       n;
    int          err_count;
    int          n_compared;
    int          seed;

    irq_ctl dut_u (
        .mclk(mclk), .rst(rst), .irq_in(irq_in), .svc_done(svc_done),
        .svc_req(svc_req), .svc_active(svc_active), .error_flag(error_flag),
        .irq(irq), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
    );

    // -----------------------------------------------------------------
    // Clock, compare and verdict
    // -----------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict

    // Read results are valid in the access cycle, so notes are matched there
    always @(posedge mclk) begin
        if (psel && penable && pready && !pwrite) begin
            n = q.pop_front();
            cmp("read data", n.d & n.m, prdata & n.m);
            cmp("slave error", {31'h0, n.e}, {31'h0, pslverr});
        end
    end

    // -----------------------------------------------------------------
    // Bus and command tasks
    // -----------------------------------------------------------------
    // Request held until pready is seen high, released only after that edge
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(logic [11:0] a, logic [31:0] e, logic [31:0] m = 32'hffffffff,
                      logic se = 1'b0);
        q.push_back('{e, m, se});
        apb(1'b0, a, 32'h0);
    endtask : rd

    // Word first, then go; done and error land one edge after the go edge
    task automatic cmd(logic [11:0] code, logic [15:0] w, logic er);
        apb(1'b1, irq_ctl_pkg::OFS_WORD, {16'h0, w});
        apb(1'b1, irq_ctl_pkg::OFS_CMD, {1'b1, 19'h0, code});
        repeat (3) @(posedge mclk);
        rd(irq_ctl_pkg::OFS_STATUS, {30'h0, 1'b1, er}, 32'h3);
        cmp("error flag", {31'h0, er}, {31'h0, error_flag});
        cmp("irq", {31'h0, er & imask}, {31'h0, irq});
        apb(1'b1, irq_ctl_pkg::OFS_STATUS, 32'h7);
    endtask : cmd

    task automatic fire(int i);
        @(posedge mclk);
        irq_in <= 4'(1 << i);
        repeat (2) @(posedge mclk);
        irq_in <= 4'h0;
        repeat (4) @(posedge mclk);
    endtask : fire

    task automatic fin;
        @(posedge mclk);
        svc_done <= 1'b1;
        @(posedge mclk);
        svc_done <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask : fin

    // Hang guard, well beyond the few hundred cycles the tests need
    initial begin
        #(50 * 20000);
        err_count++;
        $display("watchdog expired");
        give_verdict();
    end

    // -----------------------------------------------------------------
    // Test sequence
    // -----------------------------------------------------------------
    initial begin
        {rst, svc_done, psel, penable, pwrite, imask} = 6'b100000;
        {irq_in, paddr, pwdata} = '0;
        err_count = 0;
        n_compared = 0;
        seed = 32'hd3e8183a;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        rd(irq_ctl_pkg::OFS_STATUS, 32'h0);
        rd(irq_ctl_pkg::OFS_PENDING, 32'h0);
        rd(12'h0fc, 32'h0, 32'hffffffff, 1'b1);
        apb(1'b1, irq_ctl_pkg::OFS_INT_MASK, 32'h1);
        imask = 1'b1;
        $display("test reset done");
        msk = 4'($random(seed));
        cmd(irq_ctl_pkg::CODE_MASK, {12'h0, msk}, 1'b0);
        cmd(irq_ctl_pkg::CODE_READ, 16'h0, 1'b0);
        rd(irq_ctl_pkg::OFS_RESULT, {28'h0, msk}, 32'hf);
        cmd(irq_ctl_pkg::CODE_MASK, 16'h0002, 1'b0);
        fire(1);
        cmp("svc_req", 32'h0, {28'h0, svc_req});
        rd(irq_ctl_pkg::OFS_PENDING, 32'h22, 32'h1ff);
        cmd(irq_ctl_pkg::CODE_MASK, 16'h0, 1'b0);
        cmp("svc_req", 32'h2, {28'h0, svc_req});
        cmd(irq_ctl_pkg::CODE_MASK_ALL, 16'h0, 1'b1);
        fin();
        cmp("svc_active", 32'h0, {31'h0, svc_active});
        $display("test mask and service done");
        cmd(irq_ctl_pkg::CODE_MASK, 16'h0001, 1'b0);
        fire(0);
        cmd(irq_ctl_pkg::CODE_CLEAR, 16'h0001, 1'b0);
        cmd(irq_ctl_pkg::CODE_MASK, 16'h0, 1'b0);
        cmp("svc_req", 32'h0, {28'h0, svc_req});
        rd(irq_ctl_pkg::OFS_PENDING, 32'h0, 32'h1ff);
        $display("test clear done");
        cmd(irq_ctl_pkg::CODE_UNM_ALL, 16'h0, 1'b1);
        cmd(irq_ctl_pkg::CODE_MASK_ALL, 16'h0, 1'b0);
        cmd(irq_ctl_pkg::CODE_MASK_ALL, 16'h0, 1'b1);
        fire(3);
        cmp("svc_req", 32'h0, {28'h0, svc_req});
        rd(irq_ctl_pkg::OFS_PENDING, 32'h108, 32'h10f);
        cmd(irq_ctl_pkg::CODE_UNM_ALL, 16'h0, 1'b0);
        cmp("svc_req", 32'h8, {28'h0, svc_req});
        fin();
        $display("test global done");
        // illegal requests and go left low
        cmd(12'h004, 16'h0, 1'b1);
        cmd(irq_ctl_pkg::CODE_MASK, 16'h0011, 1'b1);
        cmd(irq_ctl_pkg::CODE_MASK_ALL, 16'h0001, 1'b1);
        apb(1'b1, irq_ctl_pkg::OFS_WORD, 32'hf);
        apb(1'b1, irq_ctl_pkg::OFS_CMD, {20'h0, irq_ctl_pkg::CODE_MASK});
        repeat (4) @(posedge mclk);
        rd(irq_ctl_pkg::OFS_PENDING, 32'h0, 32'h1f0);
        $display("test illegal done");
        // reload with bad and good set values
        cmd(irq_ctl_pkg::CODE_RELOAD, 16'h0001, 1'b1);
        apb(1'b1, irq_ctl_pkg::OFS_SET_BASE, 32'h5);
        cmd(irq_ctl_pkg::CODE_RELOAD, 16'h0001, 1'b0);
        rd(irq_ctl_pkg::OFS_SET_BASE, 32'h00050005);
        // Masked error does not reach irq
        imask = 1'b0;
        apb(1'b1, irq_ctl_pkg::OFS_INT_MASK, 32'h0);
        cmd(12'h3ff, 16'h0, 1'b1);
        $display("test reload and irq done");
        give_verdict();
    end
endmodule : input_interrupt_control_tb
